// ### design/cawr_core.sv
/*
 * Datapath of an 8-bit core: four-phase instruction cycle, two-stage
 * fetch/execute pipeline, accumulator, status flags and the special
 * function registers held inside the core.
 * Assumes program memory returns the word at o_prog_addr in the same cycle
 * and data memory returns read data in the cycle o_data_rd is high.
 */
//
// Summary of operation
// - alu works on 8-bit operands: add, subtract, shift, logic
// - arithmetic uses two's complement on the 8-bit operands
// - two-operand ops use accumulator plus file register or immediate constant
// - single-operand ops take accumulator or a file register
// - accumulator is 8 bits, operand storage, has no data-memory address
// - alu updates carry, nibble carry and zero flags per instruction
// - on subtract, carry and nibble carry are inverted borrows
// - each instruction is one 14-bit word fetched per cycle on own bus
// - fetch overlaps execute; all but branches take one instruction cycle
// - program and data memories use separate buses
// - special function registers, program counter too, sit in data memory
// - file registers reachable directly and indirectly with any operation
// - instruction cycle is four phases from clock divided by four
// - operand read in operand read phase, result written in write phase
// - program counter change takes two cycles; prefetched word discarded
`timescale 1ns/100ps
module cawr_core
  import cawr_pkg::*;
#(
  parameter int PC_W = 11
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [13:0] i_prog_data,
  output logic [PC_W-1:0] o_prog_addr,
  output logic o_prog_latch,
  input wire logic [7:0] i_data_rdata,
  output logic [7:0] o_data_addr,
  output logic o_data_rd,
  output logic o_data_wr,
  output logic [7:0] o_data_wdata,
  output logic [7:0] o_acc,
  output logic [2:0] o_status,
  output logic [3:0] o_phase
);

  cawr_phase_t phase_reg;
  logic [PC_W-1:0] pc_reg;
  logic [13:0] fetch_reg;
  logic flush_reg;
  logic [13:0] insn_reg;
  logic [7:0] addr_reg;
  logic [7:0] operand_reg;
  logic [7:0] acc_reg;
  logic [7:0] pointer_reg;
  logic [2:0] status_reg;
  logic [7:0] result_reg;
  logic [2:0] flags_reg;

  logic [1:0] insn_class;
  logic [3:0] insn_op;
  logic dest_file;
  logic is_lit;
  logic is_jump;
  logic is_byte;
  cawr_alu_op_t alu_op;
  logic [2:0] flag_mask;
  logic [7:0] alu_result;
  logic alu_carry;
  logic alu_nibble;
  logic alu_zero;
  logic addr_internal;
  logic [7:0] core_rdata;
  logic write_file;
  logic pc_write;
  logic [13:0] next_insn;

  // ********************************************************
  // phase sequencer: clock divided by four
  // ********************************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase_reg <= PH_DECODE;
    end else begin
      case (phase_reg)
        PH_DECODE: phase_reg <= PH_OPERAND_READ;
        PH_OPERAND_READ: phase_reg <= PH_EXECUTE;
        PH_EXECUTE: phase_reg <= PH_RESULT_WRITE;
        PH_RESULT_WRITE: phase_reg <= PH_DECODE;
        default: phase_reg <= PH_DECODE;
      endcase
    end
  end

  // ********************************************************
  // decode of the executing instruction
  // ********************************************************
  always_comb begin
    insn_class = insn_reg[CLS_HI:CLS_LO];
    insn_op = insn_reg[OP_HI:OP_LO];
    dest_file = insn_reg[DEST_BIT];
    is_lit = (insn_class == CLS_LIT);
    is_jump = (insn_class == CLS_JUMP) && !insn_reg[JUMP_SEL];
    is_byte = (insn_class == CLS_BYTE);
    alu_op = ALU_NONE_F;
    flag_mask = FLAGS_NONE;
    if (is_byte) begin
      alu_op = cawr_alu_op_t'(insn_op);
      case (alu_op)
        ALU_ZERO, ALU_DEC, ALU_OR, ALU_AND, ALU_XOR: flag_mask = FLAGS_Z;
        ALU_PASS_F, ALU_COM, ALU_INC: flag_mask = FLAGS_Z;
        ALU_SUB, ALU_ADD: flag_mask = FLAGS_CDZ;
        ALU_RL, ALU_RR: flag_mask = FLAGS_C;
        default: flag_mask = FLAGS_NONE;
      endcase
    end else if (is_lit) begin
      case (insn_op)
        LIT_MOVE: alu_op = ALU_PASS_F;
        LIT_OR: alu_op = ALU_OR;
        LIT_AND: alu_op = ALU_AND;
        LIT_XOR: alu_op = ALU_XOR;
        LIT_SUB: alu_op = ALU_SUB;
        LIT_ADD: alu_op = ALU_ADD;
        default: alu_op = ALU_NONE_F;
      endcase
      case (insn_op)
        LIT_OR, LIT_AND, LIT_XOR: flag_mask = FLAGS_Z;
        LIT_SUB, LIT_ADD: flag_mask = FLAGS_CDZ;
        default: flag_mask = FLAGS_NONE;
      endcase
    end
  end

  // file operation whose opcode is a real operation and whose target is a file
  assign write_file = is_byte && dest_file && (insn_op < 4'hE);
  assign pc_write = write_file && (addr_reg == ADR_PC_LOW);
  // a pointer of zero lands on the indirect slot itself, which never reaches the bus
  assign addr_internal = (addr_reg == ADR_INDIRECT) || (addr_reg == ADR_PC_LOW)
                         || (addr_reg == ADR_STATUS) || (addr_reg == ADR_POINTER);
  assign next_insn = flush_reg ? INSN_NOP : fetch_reg;

  always_comb begin
    core_rdata = 8'h00;
    case (addr_reg)
      ADR_INDIRECT: core_rdata = 8'h00;
      ADR_PC_LOW: core_rdata = pc_reg[7:0];
      ADR_STATUS: core_rdata = {5'h00, status_reg};
      ADR_POINTER: core_rdata = pointer_reg;
      default: core_rdata = i_data_rdata;
    endcase
  end

  // ********************************************************
  // fetch: program counter and prefetch latch
  // ********************************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pc_reg <= '0;
      fetch_reg <= INSN_NOP;
      flush_reg <= 1'b1;
    end else if (phase_reg == PH_RESULT_WRITE) begin
      fetch_reg <= i_prog_data;
      if (is_jump) begin
        pc_reg <= insn_reg[PC_W-1:0];
        flush_reg <= 1'b1;
      end else if (pc_write) begin
        pc_reg <= {pc_reg[PC_W-1:8], result_reg};
        flush_reg <= 1'b1;
      end else begin
        pc_reg <= pc_reg + 1'b1;
        flush_reg <= 1'b0;
      end
    end
  end

  // ********************************************************
  // execute stage: instruction and operand address
  // ********************************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      insn_reg <= INSN_NOP;
      addr_reg <= 8'h00;
    end else if (phase_reg == PH_DECODE) begin
      insn_reg <= next_insn;
      if (next_insn[FILE_HI:0] == ADR_INDIRECT[FILE_HI:0]) begin
        addr_reg <= pointer_reg;
      end else begin
        addr_reg <= {1'b0, next_insn[FILE_HI:0]};
      end
    end
  end

  // operand latched at the end of the operand read phase
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      operand_reg <= 8'h00;
    end else if (phase_reg == PH_OPERAND_READ) begin
      if (is_lit) begin
        operand_reg <= insn_reg[7:0];
      end else begin
        operand_reg <= core_rdata;
      end
    end
  end

  cawr_alu u_alu (
    .i_op(alu_op),
    .i_acc(acc_reg),
    .i_operand(operand_reg),
    .i_carry(status_reg[ST_CARRY]),
    .o_result(alu_result),
    .o_carry(alu_carry),
    .o_nibble(alu_nibble),
    .o_zero(alu_zero)
  );

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      result_reg <= 8'h00;
      flags_reg <= STATUS_RESET;
    end else if (phase_reg == PH_EXECUTE) begin
      result_reg <= alu_result;
      flags_reg <= {alu_zero, alu_nibble, alu_carry};
    end
  end

  // ********************************************************
  // result write: accumulator, pointer, status
  // ********************************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc_reg <= ACC_RESET;
    end else if (phase_reg == PH_RESULT_WRITE) begin
      if ((is_byte && !dest_file && insn_op < 4'hE) || (is_lit && insn_op <= LIT_ADD)) begin
        acc_reg <= result_reg;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pointer_reg <= POINTER_RESET;
    end else if (phase_reg == PH_RESULT_WRITE && write_file && addr_reg == ADR_POINTER) begin
      pointer_reg <= result_reg;
    end
  end

  // flag update from the alu takes precedence over a write to the status register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_reg <= STATUS_RESET;
    end else if (phase_reg == PH_RESULT_WRITE) begin
      for (int i = 0; i < 3; i++) begin
        if (flag_mask[i]) begin
          status_reg[i] <= flags_reg[i];
        end else if (write_file && addr_reg == ADR_STATUS) begin
          status_reg[i] <= result_reg[i];
        end
      end
    end
  end

  // ********************************************************
  // outputs: separate program and data buses
  // ********************************************************
  assign o_prog_addr = pc_reg;
  assign o_prog_latch = (phase_reg == PH_RESULT_WRITE);
  assign o_data_addr = addr_reg;
  assign o_data_rd = (phase_reg == PH_OPERAND_READ) && is_byte && !addr_internal;
  assign o_data_wr = (phase_reg == PH_RESULT_WRITE) && write_file && !addr_internal;
  assign o_data_wdata = result_reg;
  assign o_acc = acc_reg;
  assign o_status = status_reg;
  assign o_phase = phase_reg;

endmodule : cawr_core

// ### design/cawr_pkg.sv
/*
 * Constants and types shared by the core datapath and its arithmetic/logic unit.
 * Assumes a 14-bit instruction word and 8-bit data memory.
 */
package cawr_pkg;

  // ********************************************************
  // widths
  // ********************************************************
  localparam int DATA_W = 8;
  localparam int INSN_W = 14;
  localparam int ADDR_W = 8;
  localparam int PHASES_PER_CYCLE = 4;

  // ********************************************************
  // special function register addresses in data memory
  // ********************************************************
  localparam logic [7:0] ADR_INDIRECT = 8'h00;
  localparam logic [7:0] ADR_PC_LOW = 8'h02;
  localparam logic [7:0] ADR_STATUS = 8'h03;
  localparam logic [7:0] ADR_POINTER = 8'h04;

  // ********************************************************
  // status register bit positions and reset value
  // ********************************************************
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] FLAGS_NONE = 3'h0;
  localparam logic [2:0] FLAGS_C = 3'h1;
  localparam logic [2:0] FLAGS_Z = 3'h4;
  localparam logic [2:0] FLAGS_CDZ = 3'h7;

  // ********************************************************
  // instruction word fields
  // ********************************************************
  localparam int CLS_HI = 13;
  localparam int CLS_LO = 12;
  localparam int OP_HI = 11;
  localparam int OP_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int FILE_HI = 6;
  localparam int JUMP_SEL = 11;
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  localparam logic [13:0] INSN_NOP = 14'h0000;

  // literal operations, field OP_HI:OP_LO
  localparam logic [3:0] LIT_MOVE = 4'h0;
  localparam logic [3:0] LIT_OR = 4'h1;
  localparam logic [3:0] LIT_AND = 4'h2;
  localparam logic [3:0] LIT_XOR = 4'h3;
  localparam logic [3:0] LIT_SUB = 4'h4;
  localparam logic [3:0] LIT_ADD = 4'h5;

  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;

  // byte operations use the opcode field directly as the alu operation
  typedef enum logic [3:0] {
    ALU_PASS_W = 4'h0,
    ALU_ZERO = 4'h1,
    ALU_SUB = 4'h2,
    ALU_DEC = 4'h3,
    ALU_OR = 4'h4,
    ALU_AND = 4'h5,
    ALU_XOR = 4'h6,
    ALU_ADD = 4'h7,
    ALU_PASS_F = 4'h8,
    ALU_COM = 4'h9,
    ALU_INC = 4'hA,
    ALU_RL = 4'hB,
    ALU_RR = 4'hC,
    ALU_SWAP = 4'hD,
    ALU_NONE_E = 4'hE,
    ALU_NONE_F = 4'hF
  } cawr_alu_op_t;

  typedef enum logic [3:0] {
    PH_DECODE = 4'b0001,
    PH_OPERAND_READ = 4'b0010,
    PH_EXECUTE = 4'b0100,
    PH_RESULT_WRITE = 4'b1000
  } cawr_phase_t;

endpackage : cawr_pkg

// ### design/cawr_alu.sv
/*
 * 8-bit arithmetic/logic unit, purely combinational.
 * Assumes the caller registers operands and decides which flags to keep.
 */
`timescale 1ns/100ps
module cawr_alu
  import cawr_pkg::*;
(
  input wire cawr_alu_op_t i_op,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_operand,
  input wire logic i_carry,
  output logic [7:0] o_result,
  output logic o_carry,
  output logic o_nibble,
  output logic o_zero
);

  logic [8:0] add_sum;
  logic [8:0] sub_sum;
  logic [4:0] add_nib;
  logic [4:0] sub_nib;

  // ********************************************************
  // two's complement add and subtract (operand minus accumulator)
  // ********************************************************
  always_comb begin
    add_sum = {1'b0, i_operand} + {1'b0, i_acc};
    add_nib = {1'b0, i_operand[3:0]} + {1'b0, i_acc[3:0]};
    sub_sum = {1'b0, i_operand} + {1'b0, ~i_acc} + 9'h001;
    sub_nib = {1'b0, i_operand[3:0]} + {1'b0, ~i_acc[3:0]} + 5'h01;
  end

  always_comb begin
    o_carry = i_carry;
    o_nibble = 1'b0;
    o_result = i_operand;
    case (i_op)
      ALU_PASS_W: o_result = i_acc;
      ALU_ZERO: o_result = 8'h00;
      ALU_SUB: begin
        o_result = sub_sum[7:0];
        o_carry = sub_sum[8];
        o_nibble = sub_nib[4];
      end
      ALU_DEC: o_result = i_operand - 8'h01;
      ALU_OR: o_result = i_operand | i_acc;
      ALU_AND: o_result = i_operand & i_acc;
      ALU_XOR: o_result = i_operand ^ i_acc;
      ALU_ADD: begin
        o_result = add_sum[7:0];
        o_carry = add_sum[8];
        o_nibble = add_nib[4];
      end
      ALU_PASS_F: o_result = i_operand;
      ALU_COM: o_result = ~i_operand;
      ALU_INC: o_result = i_operand + 8'h01;
      ALU_RL: begin
        o_result = {i_operand[6:0], i_carry};
        o_carry = i_operand[7];
      end
      ALU_RR: begin
        o_result = {i_carry, i_operand[7:1]};
        o_carry = i_operand[0];
      end
      ALU_SWAP: o_result = {i_operand[3:0], i_operand[7:4]};
      default: o_result = i_operand;
    endcase
    o_zero = (o_result == 8'h00);
  end

endmodule : cawr_alu

// ### testbench/cawr_core_monitor.sv
/* Port timing checker for the core datapath.
   Bound to cawr_core; sees its ports only, one clock domain. */
`timescale 1ns/100ps
module cawr_core_monitor
  import cawr_pkg::*;
#(
  parameter int PC_W = 11
) (
  input logic i_clk,
  input logic i_nrst,
  input logic [PC_W-1:0] o_prog_addr,
  input logic o_prog_latch,
  input logic [7:0] o_data_addr,
  input logic o_data_rd,
  input logic o_data_wr,
  input logic [7:0] o_data_wdata,
  input logic [3:0] o_phase
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // ********
  // properties
  // ********
  a_phase_walk: assert property (
    o_phase == 4'h1 |=> o_phase == 4'h2 ##1 o_phase == 4'h4 ##1 o_phase == 4'h8)
    else $error("phase order broken");
  a_phase_wrap: assert property (
    o_phase == 4'h8 |=> o_phase == 4'h1)
    else $error("phase did not wrap");
  a_fetch_latch: assert property (
    o_prog_latch == (o_phase == 4'h8))
    else $error("fetch latch off its phase");
  a_read_once: assert property (
    o_data_rd |-> o_phase == 4'h2 ##1 (!o_data_rd) [*3])
    else $error("read outside operand read phase");
  a_write_phase: assert property (
    o_data_wr |-> o_phase == 4'h8 ##1 $stable(o_data_wdata))
    else $error("write outside result write phase");
  a_core_regs: assert property (
    (o_data_rd || o_data_wr) |-> !(o_data_addr inside {8'h00, 8'h02, 8'h03, 8'h04}))
    else $error("core register reached the data bus");
  a_pc_stands: assert property (
    o_phase != 4'h8 |=> $stable(o_prog_addr))
    else $error("program address moved mid cycle");
  a_addr_stands: assert property (
    o_phase inside {4'h4, 4'h8} |-> $stable(o_data_addr))
    else $error("data address moved mid cycle");
endmodule : cawr_core_monitor

// ### testbench/cawr_mem_model.sv
/* Program and data memories on the far side of the core.
   Reads are combinational; writes land on the rising clock edge. */
`timescale 1ns/100ps
module cawr_mem_model
  import cawr_pkg::*;
#(
  parameter int PC_W = 11
) (
  input logic i_clk,
  input logic [PC_W-1:0] i_prog_addr,
  output logic [13:0] o_prog_data,
  input logic [7:0] i_data_addr,
  input logic i_data_rd,
  input logic i_data_wr,
  input logic [7:0] i_data_wdata,
  output logic [7:0] o_data_rdata
);
  logic [13:0] prog [2**PC_W];
  logic [7:0] data [256];
  logic [7:0] last_reg;
  initial begin
    last_reg = 8'hA5;
    foreach (prog[i]) prog[i] = INSN_NOP;
    foreach (data[i]) data[i] = 8'hA5;
  end
  // fetch bus independent of data traffic
  assign o_prog_data = prog[i_prog_addr];
  // an undriven read bus shows the inverse of the last byte
  assign o_data_rdata = i_data_rd ? data[i_data_addr] : ~last_reg;
  always @(posedge i_clk) begin
    if (i_data_rd) last_reg <= data[i_data_addr];
    if (i_data_wr) data[i_data_addr] <= i_data_wdata;
  end
endmodule : cawr_mem_model

// ### testbench/cawr_core_tb_top.sv
/* Self-checking bench of the core datapath.
   Rows are loaded from address 0; the memory model serves both buses. */
`timescale 1ns/100ps
module cawr_core_tb_top
  import cawr_pkg::*;
;
  typedef struct packed {
    logic [13:0] insn;
    logic [7:0] acc;
    logic [2:0] st;
  } cawr_row_t;
  logic clk, nrst, rd, wr, latch;
  logic [10:0] prog_addr;
  logic [13:0] prog_data;
  logic [7:0] rdata, daddr, wdata, acc;
  logic [2:0] status;
  logic [3:0] phase;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  cawr_row_t rows [30] = '{
    '{14'h300F, 8'h0F, 3'h0}, '{14'h3501, 8'h10, 3'h2}, '{14'h35F0, 8'h00, 3'h5},
    '{14'h3100, 8'h00, 3'h5}, '{14'h335A, 8'h5A, 3'h1}, '{14'h320F, 8'h0A, 3'h1},
    '{14'h340A, 8'h00, 3'h7}, '{14'h3001, 8'h01, 3'h7}, '{14'h3400, 8'hFF, 3'h0},
    '{14'h00A0, 8'hFF, 3'h0}, '{14'h3001, 8'h01, 3'h0}, '{14'h0720, 8'h00, 3'h7},
    '{14'h0AA0, 8'h00, 3'h7}, '{14'h0320, 8'hFF, 3'h3}, '{14'h0B20, 8'h01, 3'h2},
    '{14'h0C20, 8'h00, 3'h2}, '{14'h0920, 8'hFF, 3'h2}, '{14'h0220, 8'h01, 3'h0},
    '{14'h0803, 8'h00, 3'h4}, '{14'h3020, 8'h20, 3'h4}, '{14'h0084, 8'h20, 3'h4},
    '{14'h0A80, 8'h20, 3'h0}, '{14'h0D00, 8'h10, 3'h0}, '{14'h301A, 8'h1A, 3'h0},
    '{14'h0082, 8'h1A, 3'h0}, '{14'h30EE, 8'h1A, 3'h0}, '{14'h201C, 8'h1A, 3'h0},
    '{14'h30EE, 8'h1A, 3'h0}, '{14'h0180, 8'h1A, 3'h4}, '{14'h0100, 8'h00, 3'h4}};

  cawr_core DUT (.i_clk(clk), .i_nrst(nrst), .i_prog_data(prog_data),
    .o_prog_addr(prog_addr), .o_prog_latch(latch), .i_data_rdata(rdata),
    .o_data_addr(daddr), .o_data_rd(rd), .o_data_wr(wr), .o_data_wdata(wdata),
    .o_acc(acc), .o_status(status), .o_phase(phase));
  cawr_mem_model mem_i (.i_clk(clk), .i_prog_addr(prog_addr), .o_prog_data(prog_data),
    .i_data_addr(daddr), .i_data_rd(rd), .i_data_wr(wr), .i_data_wdata(wdata),
    .o_data_rdata(rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  task automatic q1;
    repeat (4) @(negedge clk);
    chk(32'(phase), 32'h0000_0001);
  endtask : q1
  task automatic rst_chk;
    chk(32'({prog_addr, acc, status, phase, rd, wr}),
        32'({11'h000, 8'h00, 3'h0, 4'h1, 2'h0}));
    chk(32'({daddr, wdata, latch}), 32'h0000_0000);
  endtask : rst_chk
  task automatic stop_test;
    $display("checks=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    nrst = 1'b0;
    repeat (20) @(negedge clk);
    foreach (rows[i]) mem_i.prog[i] = rows[i].insn;
    rst_chk;
    nrst = 1'b1;
    q1;
    foreach (rows[i]) begin
      q1;
      chk(32'({acc, status}), 32'({rows[i].acc, rows[i].st}));
    end
    chk(32'(mem_i.data[8'h20]), 32'h0000_0000);
    chk(32'({mem_i.data[8'h02], mem_i.data[8'h03], mem_i.data[8'h04]}), 32'h00A5_A5A5);
    // restart, then reset in the middle of an instruction cycle
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    q1;
    q1;
    chk(32'(acc), 32'h0000_000F);
    repeat (2) @(negedge clk);
    nrst = 1'b0;
    #1 rst_chk;
    @(negedge clk);
    nrst = 1'b1;
    q1;
    q1;
    chk(32'({acc, status}), 32'({8'h0F, 3'h0}));
    stop_test;
  end
endmodule : cawr_core_tb_top

bind cawr_core cawr_core_monitor #(.PC_W(PC_W)) u_mon (.i_clk(i_clk), .i_nrst(i_nrst),
  .o_prog_addr(o_prog_addr), .o_prog_latch(o_prog_latch), .o_data_addr(o_data_addr),
  .o_data_rd(o_data_rd), .o_data_wr(o_data_wr), .o_data_wdata(o_data_wdata),
  .o_phase(o_phase));
